// file: rtl/acs_pkg.sv
// Constants, carrier types and the shared tick counter of the startup and chop sequencer.
// Operation
// - After power-on settling, wait 256 + 44 modulator periods before modulators deliver samples.
// - Drive the result-ready output from low to high when power-on settling ends.
// - Both filter paths take samples; fast settles in one period, sinc in three.
// - First two results come from the fast path, third onward from the sinc path.
// - Command or pin reset skips power-on wait, then repeats the startup sequence.
// - Default ratio gives 1024-period results, first at 1324, first sinc at 3372.
// - Continuous mode yields one result per oversampling ratio, each with a falling edge.
// - Chop mode alternates input polarity on successive conversions and averages opposite pairs.
// - Every polarity swap resets the decimation filter; three oversampling ratios make one result.
// - Four-bit chop delay selects a wait from 2 to 65,536 periods after swaps.
// - Chop result period equals delay plus three ratios, each result with a falling edge.
// - In chop mode a sync pin falling edge or ratio change restarts all channels.
// - First chopped result after restart takes two full periods plus 44 modulator periods.
// - Chop mode bypasses per-channel phase calibration regardless of its setting.
// - The internal DC test input cannot be measured while chop mode is enabled.
// - A reset command is acted on only after its frame completes, then startup runs.
`timescale 1ns/100ps
`default_nettype none
package acs_pkg;
	localparam int CLK_MHZ = 100;
	localparam int MOD_DIV = 2;
	localparam int DIV_W = 2;
	localparam int POR_TIME_US = 250;
	localparam int POR_CYCLES_DEF = POR_TIME_US * CLK_MHZ;
	localparam int RSL_TIME_NS = 20000;
	localparam int RSL_CYCLES = (RSL_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int RSL_W = 12;
	localparam int CNT_W = 18;
	localparam logic [CNT_W-1:0] INIT_MODS = 18'(256 + 44);
	localparam logic [CNT_W-1:0] TAIL_MODS = 18'(44);
	localparam logic [CNT_W-1:0] OSR_BASE = 18'h00080;
	localparam logic [CNT_W-1:0] DLY_BASE = 18'h00002;
	localparam int RESULT_READY_N_W = 4;
	localparam logic [RESULT_READY_N_W-1:0] RESULT_READY_N_LOW_MODS = 4'h8;
	localparam logic [1:0] FAST_SAMPLES = 2'h2;
	localparam logic [1:0] FIRST_PASSES = 2'h2;
	localparam logic [15:0] CMD_RESET = 16'h0011;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_STATE = 4'h3;
	localparam int CTRL_W = 10;
	localparam int STAT_W = 3;

	typedef struct packed {
		logic phase_cal_en;
		logic dc_test_sel;
		logic [2:0] oversampling_ratio;
		logic [3:0] chop_settle_delay;
		logic chop_enable;
	} acs_ctrl_t;

	localparam acs_ctrl_t CTRL_RESET = '{phase_cal_en: 1'b1, dc_test_sel: 1'b0,
		oversampling_ratio: 3'h3, chop_settle_delay: 4'h0, chop_enable: 1'b0};

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} acs_bus_req_t;

	typedef struct packed {
		logic frame_done;
		logic [15:0] code;
	} acs_cmd_t;

	typedef struct packed {
		logic result_valid;
		logic fast_filter_sel;
		logic chop_polarity;
		logic filter_reset;
		logic modulator_run;
		logic phase_cal_bypass;
		logic dc_test_allowed;
	} acs_conv_out_t;

	typedef enum logic [2:0] {
		ST_POR,
		ST_INIT,
		ST_CONV,
		ST_CHOP_DLY,
		ST_CHOP_CONV,
		ST_CHOP_TAIL
	} acs_state_t;
endpackage : acs_pkg

module acs_tick_counter #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic en,
	input wire logic [W-1:0] target,
	output logic hit
);
	logic [W-1:0] count_q;

	// Hit ignores clear so that callers may derive clear from hit without a loop.
	// A target lowered in mid-count ends the period at once instead of wrapping.
	assign hit = en && (count_q >= (target - W'(1)));

	always_ff @(posedge clk)
	begin
		if (rst || clear || hit)
			count_q <= '0;
		else if (en)
			count_q <= count_q + W'(1);
	end
endmodule : acs_tick_counter
`default_nettype wire

// file: rtl/acs_sequencer.sv
// Startup, filter handover and chop sequencing of the converter with its register port.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer #(
	parameter int POR_CYCLES = acs_pkg::POR_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sync_reset_n_pin,
	input wire acs_pkg::acs_cmd_t cmd,
	input wire acs_pkg::acs_bus_req_t bus_req,
	output logic [acs_pkg::DATA_W-1:0] bus_rdata,
	output logic result_ready_n,
	output acs_pkg::acs_conv_out_t conv,
	output logic irq
);
	import acs_pkg::*;

	acs_state_t state_q;
	acs_state_t state_d;
	acs_ctrl_t ctrl_q;
	acs_conv_out_t conv_q;
	logic [STAT_W-1:0] status_q;
	logic [STAT_W-1:0] mask_q;
	logic [2:0] osr_prev_q;
	logic chop_prev_q;
	logic [1:0] restart_cnt_q;
	logic [1:0] sample_cnt_q;
	logic result_ready_n_n_q;
	logic irq_q;
	logic [DATA_W-1:0] rdata_q;
	logic sync_s1_q;
	logic sync_s2_q;
	logic sync_s3_q;
	logic pin_hold_q;

	logic mod_tick;
	logic seq_hit;
	logic seq_en;
	logic seq_clear;
	logic pin_hit;
	logic result_ready_n_hit;
	logic [CNT_W-1:0] seq_target;
	logic result_ev;
	logic swap_ev;
	logic startup_ev;
	logic reset_now;

	// Modulator period enable; a reset realigns it so that startup counts do not jitter.
	acs_tick_counter #(
		.W(DIV_W)
	) u_mod_div (
		.clk(clk),
		.rst(rst),
		.clear(reset_now),
		.en(1'b1),
		.target(DIV_W'(MOD_DIV)),
		.hit(mod_tick)
	);

	// Sync pin: two flops before use, a third only for the edge.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync_s1_q <= 1'b1;
			sync_s2_q <= 1'b1;
			sync_s3_q <= 1'b1;
		end
		else
		begin
			sync_s1_q <= sync_reset_n_pin;
			sync_s2_q <= sync_s1_q;
			sync_s3_q <= sync_s2_q;
		end
	end

	wire sync_fall = sync_s3_q && !sync_s2_q;

	// A low pulse longer than the reset width turns into a held pin reset.
	acs_tick_counter #(
		.W(RSL_W)
	) u_pin_width (
		.clk(clk),
		.rst(rst),
		.clear(sync_s2_q),
		.en(!sync_s2_q && !pin_hold_q),
		.target(RSL_W'(RSL_CYCLES)),
		.hit(pin_hit)
	);

	always_ff @(posedge clk)
	begin
		if (rst || sync_s2_q)
			pin_hold_q <= 1'b0;
		else if (pin_hit)
			pin_hold_q <= 1'b1;
	end

	// The command is seen only with the frame-complete strobe, never mid-frame.
	wire cmd_reset = cmd.frame_done && (cmd.code == CMD_RESET);
	assign reset_now = cmd_reset || pin_hold_q;
	wire running = (state_q == ST_CONV) || (state_q == ST_CHOP_DLY)
		|| (state_q == ST_CHOP_CONV) || (state_q == ST_CHOP_TAIL);
	wire osr_changed = ctrl_q.oversampling_ratio != osr_prev_q;
	wire chop_changed = ctrl_q.chop_enable != chop_prev_q;
	wire restart = !reset_now && running && (chop_changed
		|| (ctrl_q.chop_enable && (sync_fall || osr_changed)));

	// Period lengths in modulator periods.
	wire [CNT_W-1:0] osr_len = OSR_BASE << ctrl_q.oversampling_ratio;
	wire [CNT_W-1:0] dly_len = DLY_BASE << ctrl_q.chop_settle_delay;
	wire [CNT_W-1:0] conv_len = osr_len + (osr_len << 1);

	always_comb
	begin
		case (state_q)
			ST_POR: seq_target = CNT_W'(POR_CYCLES);
			ST_INIT: seq_target = INIT_MODS;
			ST_CONV: seq_target = osr_len;
			ST_CHOP_DLY: seq_target = dly_len;
			ST_CHOP_CONV: seq_target = conv_len;
			ST_CHOP_TAIL: seq_target = TAIL_MODS;
			default: seq_target = INIT_MODS;
		endcase
	end

	// Power-on settling counts clock cycles; everything after it counts modulator periods.
	assign seq_en = (state_q == ST_POR) || mod_tick;
	assign seq_clear = reset_now || restart || (state_d != state_q);

	acs_tick_counter #(
		.W(CNT_W)
	) u_seq (
		.clk(clk),
		.rst(rst),
		.clear(seq_clear),
		.en(seq_en),
		.target(seq_target),
		.hit(seq_hit)
	);

	always_comb
	begin
		state_d = state_q;
		result_ev = 1'b0;
		swap_ev = 1'b0;
		startup_ev = 1'b0;
		if (reset_now)
			state_d = ST_INIT;
		else if (restart)
			state_d = ctrl_q.chop_enable ? ST_CHOP_DLY : ST_CONV;
		else if (seq_hit)
		begin
			case (state_q)
				ST_POR:
					state_d = ST_INIT;
				ST_INIT:
				begin
					startup_ev = 1'b1;
					state_d = ctrl_q.chop_enable ? ST_CHOP_DLY : ST_CONV;
				end
				ST_CONV:
					result_ev = 1'b1;
				ST_CHOP_DLY:
					state_d = ST_CHOP_CONV;
				ST_CHOP_CONV:
				begin
					swap_ev = 1'b1;
					if (restart_cnt_q == 2'h1)
						state_d = ST_CHOP_TAIL;
					else
					begin
						state_d = ST_CHOP_DLY;
						result_ev = (restart_cnt_q == 2'h0);
					end
				end
				ST_CHOP_TAIL:
				begin
					result_ev = 1'b1;
					state_d = ST_CHOP_DLY;
				end
				default:
					state_d = ST_INIT;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_q <= ST_POR;
		else
			state_q <= state_d;
	end

	// Restart bookkeeping: a fresh chop run owes two passes before its first result.
	always_ff @(posedge clk)
	begin
		if (rst || reset_now)
			restart_cnt_q <= FIRST_PASSES;
		else if (restart || startup_ev)
			restart_cnt_q <= FIRST_PASSES;
		else if (swap_ev && (restart_cnt_q != 2'h0))
			restart_cnt_q <= restart_cnt_q - 2'h1;
	end

	always_ff @(posedge clk)
	begin
		if (rst || reset_now)
		begin
			osr_prev_q <= CTRL_RESET.oversampling_ratio;
			chop_prev_q <= CTRL_RESET.chop_enable;
		end
		else
		begin
			osr_prev_q <= ctrl_q.oversampling_ratio;
			chop_prev_q <= ctrl_q.chop_enable;
		end
	end

	// Results since startup decide which filter path feeds the output.
	always_ff @(posedge clk)
	begin
		if (rst || reset_now || startup_ev)
			sample_cnt_q <= 2'h0;
		else if (result_ev && (sample_cnt_q != FAST_SAMPLES))
			sample_cnt_q <= sample_cnt_q + 2'h1;
	end

	// Result-ready: low through settling, high when ready, then low for a short pulse per result.
	acs_tick_counter #(
		.W(RESULT_READY_N_W)
	) u_result_ready_n (
		.clk(clk),
		.rst(rst),
		.clear(result_ev),
		.en(mod_tick && !result_ready_n_n_q),
		.target(RESULT_READY_N_LOW_MODS),
		.hit(result_ready_n_hit)
	);

	always_ff @(posedge clk)
	begin
		if (rst || reset_now)
			result_ready_n_n_q <= 1'b0;
		else if (state_q == ST_POR)
			result_ready_n_n_q <= seq_hit;
		else if (state_q == ST_INIT)
			result_ready_n_n_q <= 1'b1;
		else if (result_ev)
			result_ready_n_n_q <= 1'b0;
		else if (result_ready_n_hit)
			result_ready_n_n_q <= 1'b1;
	end

	// Filter and front-end controls.
	always_ff @(posedge clk)
	begin
		if (rst || reset_now)
			conv_q <= '0;
		else
		begin
			conv_q.result_valid <= result_ev;
			conv_q.filter_reset <= swap_ev || restart;
			conv_q.phase_cal_bypass <= ctrl_q.chop_enable || !ctrl_q.phase_cal_en;
			conv_q.dc_test_allowed <= ctrl_q.dc_test_sel && !ctrl_q.chop_enable;
			if (startup_ev)
				conv_q.modulator_run <= 1'b1;
			if (startup_ev)
				conv_q.fast_filter_sel <= !ctrl_q.chop_enable;
			else if (restart && ctrl_q.chop_enable)
				conv_q.fast_filter_sel <= 1'b0;
			else if (result_ev && (sample_cnt_q == FAST_SAMPLES))
				conv_q.fast_filter_sel <= 1'b0;
			if (restart || !ctrl_q.chop_enable)
				conv_q.chop_polarity <= 1'b0;
			else if (swap_ev)
				conv_q.chop_polarity <= !conv_q.chop_polarity;
		end
	end

	// Register port decode.
	wire wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);
	wire wr_mask = bus_req.wr && (bus_req.addr == ADDR_MASK);
	wire rd_status = bus_req.rd && (bus_req.addr == ADDR_STATUS);
	wire [STAT_W-1:0] stat_ev = {restart, startup_ev, result_ev};
	wire [DATA_W-1:0] state_word = DATA_W'({state_q, restart_cnt_q, sample_cnt_q,
		result_ready_n_n_q, conv_q.chop_polarity, conv_q.fast_filter_sel, conv_q.modulator_run});
	wire [DATA_W-1:0] rd_mux =
		(bus_req.addr == ADDR_CTRL) ? DATA_W'(ctrl_q) :
		(bus_req.addr == ADDR_STATUS) ? DATA_W'(status_q) :
		(bus_req.addr == ADDR_MASK) ? DATA_W'(mask_q) :
		(bus_req.addr == ADDR_STATE) ? state_word : '0;

	// Configuration returns to defaults on any reset, like the rest of the device.
	always_ff @(posedge clk)
	begin
		if (rst || reset_now)
			ctrl_q <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl_q <= acs_ctrl_t'(bus_req.wdata[CTRL_W-1:0]);
	end

	always_ff @(posedge clk)
	begin
		if (rst || reset_now)
			mask_q <= '0;
		else if (wr_mask)
			mask_q <= bus_req.wdata[STAT_W-1:0];
	end

	// A new event in the reading cycle survives the clear-on-read.
	always_ff @(posedge clk)
	begin
		if (rst || reset_now)
			status_q <= '0;
		else
			status_q <= (status_q & ~{STAT_W{rd_status}}) | stat_ev;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irq_q <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			irq_q <= |(status_q & mask_q);
			rdata_q <= bus_req.rd ? rd_mux : '0;
		end
	end

	assign bus_rdata = rdata_q;
	assign result_ready_n = result_ready_n_n_q;
	assign conv = conv_q;
	assign irq = irq_q;
endmodule : acs_sequencer
`default_nettype wire

// file: tb/acs_seq_chk_sva.sv
// Concurrent checks on the ports of the startup and chop sequencer.
`timescale 1ns/100ps
`default_nettype none
module acs_seq_chk #(
	parameter int POR_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire acs_pkg::acs_cmd_t cmd,
	input wire acs_pkg::acs_bus_req_t bus_req,
	input wire logic [acs_pkg::DATA_W-1:0] bus_rdata,
	input wire logic result_ready_n,
	input wire acs_pkg::acs_conv_out_t conv
);
	import acs_pkg::*;
	int por_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk)
		por_cnt <= rst ? 0 : por_cnt + 1;
	sequence reset_cmd_s;
		cmd.frame_done && cmd.code == CMD_RESET;
	endsequence
	sequence new_result_s;
		conv.result_valid;
	endsequence
	por_wait_a: assert property ($rose(result_ready_n) && por_cnt < POR_CYCLES - 2 |-> 1'b0)
		else $error("ready rose early");
	valid_result_ready_n_a: assert property (new_result_s |-> !result_ready_n)
		else $error("result without ready low");
	ready_low_a: assert property (new_result_s |=> !result_ready_n [*8])
		else $error("ready low too short");
	valid_pulse_a: assert property (new_result_s |=> !conv.result_valid)
		else $error("valid too long");
	cmd_reset_a: assert property (reset_cmd_s |=> !result_ready_n && !conv.modulator_run)
		else $error("reset command ignored");
	rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == '0)
		else $error("read data outside slot");
	chop_sinc_a: assert property (conv.chop_polarity |-> !conv.fast_filter_sel)
		else $error("fast path in chop");
	chop_bypass_a: assert property (conv.chop_polarity |-> conv.phase_cal_bypass)
		else $error("phase cal not bypassed");
	chop_dc_a: assert property (conv.chop_polarity |-> !conv.dc_test_allowed)
		else $error("dc test in chop");
	swap_reset_a: assert property ($changed(conv.chop_polarity) |-> conv.filter_reset || $past(conv.filter_reset))
		else $error("swap without filter reset");
endmodule : acs_seq_chk
`default_nettype wire

// file: tb/acs_host_model.sv
// Host that counts result announcements and keeps those after the fast-path ones.
`timescale 1ns/100ps
`default_nettype none
module acs_host_model (
	input wire logic clk,
	input wire logic clr,
	input wire logic result_ready_n,
	output int falls,
	output int kept
);
	logic ready_q;
	always_ff @(posedge clk)
	begin
		ready_q <= result_ready_n;
		if (clr)
		begin
			falls <= 0;
			kept <= 0;
		end
		else if (ready_q && !result_ready_n)
		begin
			falls <= falls + 1;
			if (falls >= 2)
				kept <= kept + 1;
		end
	end
endmodule : acs_host_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the startup and chop sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import acs_pkg::*;
	localparam int POR = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pin_n = 1'b1;
	logic host_clr = 1'b1;
	acs_cmd_t cmd = '0;
	acs_bus_req_t req = '0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] v;
	logic result_ready_n_n;
	logic irq;
	acs_conv_out_t conv;
	int err_total = 0;
	int comparisons = 0;
	int falls;
	int kept;
	int n;
	int d;
	int per;
	always #5 clk = ~clk;
	acs_sequencer #(.POR_CYCLES(POR)) acs_sequencer_i (.clk(clk), .rst(rst),
		.sync_reset_n_pin(pin_n), .cmd(cmd), .bus_req(req), .bus_rdata(rdata),
		.result_ready_n(result_ready_n_n), .conv(conv), .irq(irq));
	acs_host_model acs_host_model_i (.clk(clk), .clr(host_clr), .result_ready_n(result_ready_n_n),
		.falls(falls), .kept(kept));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task automatic wr(input logic [3:0] a, input logic [15:0] w);
		@(posedge clk);
		req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 v = rdata;
	endtask : rd
	task automatic wait_valid();
		n = 0;
		do
		begin
			@(posedge clk);
			#1 n++;
		end
		while (conv.result_valid !== 1'b1 && n < 20000);
		if (n >= 20000)
			err_total++;
	endtask : wait_valid
	task automatic startup(input int lag);
		n = 0;
		while (result_ready_n_n !== 1'b1 && n < 5000)
		begin
			@(posedge clk);
			#1 n++;
		end
		host_clr = 1'b0;
		wait_valid();
		chk(n + lag, (256 + 44 + 1024) * MOD_DIV);
		chk(conv.fast_filter_sel, 1'b1);
		wait_valid();
		chk(n, 1024 * MOD_DIV);
		chk(conv.fast_filter_sel, 1'b1);
		wait_valid();
		chk(conv.fast_filter_sel, 1'b0);
		@(posedge clk);
		#1 chk(kept, 1);
	endtask : startup
	initial
	begin
		n = $urandom(32'h22909a52);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		startup(0);
		rd(ADDR_CTRL);
		chk(v, 16'h0260);
		rd(ADDR_MASK);
		chk(v, 16'h0000);
		rd(4'hf);
		chk(v, 16'h0000);
		wr(ADDR_MASK, 16'h0001);
		wait_valid();
		repeat (2) @(posedge clk);
		#1 chk(irq, 1'b1);
		rd(ADDR_STATUS);
		chk(v[0], 1'b1);
		wr(ADDR_MASK, 16'h0000);
		#1 chk(irq, 1'b0);
		wr(ADDR_CTRL, 16'h0000);
		host_clr = 1'b1;
		@(posedge clk);
		cmd <= '{frame_done: 1'b1, code: 16'h0022};
		@(posedge clk);
		cmd <= '{frame_done: 1'b1, code: CMD_RESET};
		#1 chk(conv.modulator_run, 1'b1);
		@(posedge clk);
		cmd <= '0;
		#1 chk({conv.modulator_run, result_ready_n_n}, 2'b00);
		startup(1);
		rd(ADDR_CTRL);
		chk(v, 16'h0260);
		host_clr = 1'b1;
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (RSL_CYCLES + 100) @(posedge clk);
		pin_n <= 1'b1;
		startup(1);
		for (int i = 0; i < 3; i++)
		begin
			d = $urandom % 3;
			per = ((2 << d) + 3 * (128 << (i % 2))) * MOD_DIV;
			wr(ADDR_CTRL, 16'(32'h0301 | (d << 1) | ((i % 2) << 5)));
			wait_valid();
			chk(n >= per * 2 + 44 * MOD_DIV && n <= per * 2 + 44 * MOD_DIV + 1, 1'b1);
			chk({conv.phase_cal_bypass, conv.dc_test_allowed}, 2'b10);
			chk(conv.chop_polarity, 1'b0);
			wait_valid();
			chk(n, per);
			chk(conv.chop_polarity, 1'b1);
		end
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		pin_n <= 1'b1;
		wait_valid();
		chk(n >= per * 2 + 44 * MOD_DIV - 2 && n <= per * 2 + 44 * MOD_DIV - 1, 1'b1);
		test_done();
	end
	initial
	begin
		#(80000 * 10);
		err_total++;
		test_done();
	end
endmodule : tb
bind acs_sequencer acs_seq_chk #(.POR_CYCLES(POR_CYCLES)) acs_seq_chk_i (.clk(clk), .rst(rst),
	.cmd(cmd), .bus_req(bus_req), .bus_rdata(bus_rdata), .result_ready_n(result_ready_n),
	.conv(conv));
`default_nettype wire
